/* File: hdl/sfc_top.sv */
// Sensor queue packing, user control and power management registers
// Functional notes
// - Sample bytes go in order temp, rate X/Y/Z, accel X/Y/Z, high byte first.
// - An enabled trailer word is appended last to each sample.
// - Leftover word from the previous burst is read before newer data.
// - Each data read returns oldest byte, advances and prefetches the next.
// - On overflow new bytes overwrite the oldest; latest 512 bytes kept.
// - Byte count reports stored bytes, saturating at 512.
// - First byte of the overflow read-out burst is invalid.
// - User control at 3d: enables bits 7:5, resets bits 3:0, bit4 unused.
// - Reset bits clear themselves once their function is reset.
// - Enable with reset starts queue storage at the next sample.
// - Queue reset empties the queue; host sets it when toggling enable.
// - Master disabled plus its reset gives primary bus pass-through.
// - Secondary master only burst reads; configuration goes via pass-through.
// - Power register at 3e: reset, sleep, three standby bits, clock select.
// - Hard reset bit returns all registers to defaults.
// - Standby bit 1 puts that gyro axis to standby.
// - Sleep keeps only interface and registers alive.
// - Clock codes: internal, PLL gyro X/Y/Z, PLL external references, reserved.
// - Code 7 stops the clock and holds the queue and sample packer in reset.
// - Device starts on the internal oscillator.
`timescale 1ns/1ps
`default_nettype none
module sfc_top (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic ce,
  // Primary bus
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Secondary bus
  input wire logic aux_sda_in,
  output logic aux_scl_out,
  output logic aux_scl_oe,
  output logic aux_sda_out,
  output logic aux_sda_oe,
  // Samples
  input wire logic sample_strobe,
  input wire sfc_pkg::sfc_sample_t sample,
  input wire logic [7:0] item_enable,
  // Clock source
  input wire logic pll_lock,
  output logic [2:0] clk_src,
  output logic clock_stop,
  // Function controls
  output logic coproc_enable,
  output logic coproc_reset,
  output logic aux_master_enable,
  output logic aux_reset,
  output logic gyro_reset,
  output logic passthrough,
  output logic sleep,
  output logic standby_gyro_x,
  output logic standby_gyro_y,
  output logic standby_gyro_z
);
  import sfc_pkg::*;
  sfc_reg_req_t req;
  logic [7:0] reg_addr, rd_mux, q_rd_data, uc, pm, next_uc, next_pm;
  logic [SFC_CNT_W-1:0] q_count;
  logic slv_oe, scl_s, sda_s, q_clear, q_rd, q_wr;
  logic [7:0] q_wdata;
  logic [1:0] lock_p, aux_p;
  logic next_pt;
  logic [2:0] next_src;
  logic next_stop, fwd, back, next_fwd, next_back, next_scl_oe;
  sfc_pk_st_t pk_st, next_pk_st;
  sfc_sample_t smp, next_smp;
  logic [7:0] mask, next_mask;
  logic [2:0] item, next_item;
  logic lo, next_lo;
  logic [15:0] word;

  function automatic logic [15:0] item_word(input sfc_sample_t s, input logic [2:0] i);
    case (i)
      3'h0: item_word = s.temp;
      3'h1: item_word = s.rate_x_sample;
      3'h2: item_word = s.rate_y_sample;
      3'h3: item_word = s.rate_z_sample;
      3'h4: item_word = s.accel_x_sample;
      3'h5: item_word = s.accel_y_sample;
      3'h6: item_word = s.accel_z_sample;
      default: item_word = SFC_TRAILER;
    endcase
  endfunction : item_word

  sfc_i2c_slave u_slave (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .ce(ce),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .sda_oe(slv_oe),
    .scl_s(scl_s),
    .sda_s(sda_s),
    .req(req),
    .reg_addr(reg_addr),
    .rd_data(rd_mux)
  );

  sfc_queue u_queue (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .ce(ce),
    .clear(q_clear),
    .wr(q_wr),
    .wr_data(q_wdata),
    .rd(q_rd),
    .rd_data(q_rd_data),
    .count(q_count)
  );

  // Register read view
  always_comb begin
    case (reg_addr)
      SFC_REG_CNT_H: rd_mux = {6'h00, q_count[9:8]};
      SFC_REG_CNT_L: rd_mux = q_count[7:0];
      SFC_REG_QDATA: rd_mux = q_rd_data;
      SFC_REG_UCTRL: rd_mux = uc;
      SFC_REG_PWR: rd_mux = pm;
      default: rd_mux = 8'h00;
    endcase
  end

  // Control, power and clock source registers
  always_comb begin
    next_uc = uc;
    next_pm = pm;
    next_pt = passthrough;
    next_src = clk_src;
    next_uc[3:0] = 4'h0;
    if (uc[SFC_UC_AUX_RST] && !uc[SFC_UC_AUX_EN]) next_pt = 1'b1;
    if (uc[SFC_UC_AUX_EN]) next_pt = 1'b0;
    if (req.wr && req.addr == SFC_REG_UCTRL) next_uc = req.data & SFC_UC_MASK;
    if (req.wr && req.addr == SFC_REG_PWR) next_pm = req.data;
    if (pm[2:0] == SFC_CLK_INT || pm[2:0] == SFC_CLK_STOP) next_src = pm[2:0];
    else if (pm[2:0] >= SFC_CLK_PLL_LO && pm[2:0] <= SFC_CLK_PLL_HI && lock_p[1])
      next_src = pm[2:0];
    if (pm[SFC_PM_HRESET]) begin
      next_uc = SFC_UC_RST;
      next_pm = SFC_PM_RST;
      next_pt = 1'b0;
    end
    next_stop = (next_src == SFC_CLK_STOP);
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      uc <= SFC_UC_RST;
      pm <= SFC_PM_RST;
      passthrough <= 1'b0;
      clk_src <= SFC_CLK_INT;
      clock_stop <= 1'b0;
    end else if (ce) begin
      uc <= next_uc;
      pm <= next_pm;
      passthrough <= next_pt;
      clk_src <= next_src;
      clock_stop <= next_stop;
    end
  end

  assign coproc_enable = uc[SFC_UC_COPROC_EN];
  assign coproc_reset = uc[SFC_UC_COPROC_RST];
  assign aux_master_enable = uc[SFC_UC_AUX_EN];
  assign aux_reset = uc[SFC_UC_AUX_RST];
  assign gyro_reset = uc[SFC_UC_GYRO_RST];
  assign sleep = pm[SFC_PM_SLEEP];
  assign standby_gyro_x = pm[SFC_PM_STBY_X];
  assign standby_gyro_y = pm[SFC_PM_STBY_Y];
  assign standby_gyro_z = pm[SFC_PM_STBY_Z];

  // Queue clear on its reset bit, hard reset or stopped clock
  assign q_clear = uc[SFC_UC_QUEUE_RST] || pm[SFC_PM_HRESET] || clock_stop;
  assign q_rd = req.rd && req.addr == SFC_REG_QDATA;

  // Sample packer
  always_comb begin
    word = item_word(smp, item);
    q_wr = (pk_st == SFC_PK_RUN) && mask[item];
    q_wdata = lo ? word[7:0] : word[15:8];
    next_pk_st = pk_st;
    next_smp = smp;
    next_mask = mask;
    next_item = item;
    next_lo = lo;
    if (q_clear) begin
      next_pk_st = SFC_PK_IDLE;
    end else begin
      case (pk_st)
        SFC_PK_IDLE: begin
          if (sample_strobe && uc[SFC_UC_QUEUE_EN] && !sleep && item_enable != 8'h00) begin
            next_smp = sample;
            next_mask = item_enable;
            next_item = 3'h0;
            next_lo = 1'b0;
            next_pk_st = SFC_PK_RUN;
          end
        end
        SFC_PK_RUN: begin
          if (q_wr && !lo) next_lo = 1'b1;
          else begin
            next_lo = 1'b0;
            next_item = 3'(item + 1'b1);
            if (item == SFC_LAST_ITEM) next_pk_st = SFC_PK_IDLE;
          end
        end
        default: next_pk_st = SFC_PK_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pk_st <= SFC_PK_IDLE;
      smp <= '0;
      mask <= 8'h00;
      item <= 3'h0;
      lo <= 1'b0;
    end else if (ce) begin
      pk_st <= next_pk_st;
      smp <= next_smp;
      mask <= next_mask;
      item <= next_item;
      lo <= next_lo;
    end
  end

  // Pass-through pin drive with a lockout against echoing our own drive
  always_comb begin
    next_fwd = passthrough && !sda_s && !back;
    next_back = passthrough && !aux_p[1] && !fwd;
    next_scl_oe = passthrough && !scl_s;
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      lock_p <= 2'h0;
      aux_p <= 2'h3;
      fwd <= 1'b0;
      back <= 1'b0;
      aux_scl_oe <= 1'b0;
      sda_oe <= 1'b0;
    end else if (ce) begin
      lock_p <= {lock_p[0], pll_lock};
      aux_p <= {aux_p[0], aux_sda_in};
      fwd <= next_fwd;
      back <= next_back;
      aux_scl_oe <= next_scl_oe;
      sda_oe <= slv_oe || back;
    end
  end

  assign aux_sda_oe = fwd;
  assign sda_out = 1'b0;
  assign aux_scl_out = 1'b0;
  assign aux_sda_out = 1'b0;

  default clocking dc @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  self_clear_a: assert property (ce && uc[3:0] != 4'h0 && !req.wr |=> uc[3:0] == 4'h0)
    else $error("reset bits did not self clear");
  queue_empty_a: assert property (ce && uc[SFC_UC_QUEUE_RST] |=> q_count == '0)
    else $error("queue reset did not empty queue");
  hard_reset_a: assert property (ce && pm[SFC_PM_HRESET]
    |=> uc == SFC_UC_RST && pm == SFC_PM_RST)
    else $error("hard reset left registers set");
  pass_through_a: assert property (passthrough
    |-> !uc[SFC_UC_AUX_EN] || $past(!uc[SFC_UC_AUX_EN]))
    else $error("pass-through while master enabled");
  sleep_idle_a: assert property (ce && sleep && pk_st == SFC_PK_IDLE
    |=> pk_st == SFC_PK_IDLE)
    else $error("packer started while asleep");
  clock_hold_a: assert property (ce && pm[2:0] == SFC_CLK_STOP && !req.wr && !pm[7]
    |=> ##1 clock_stop && pk_st == SFC_PK_IDLE)
    else $error("stop code did not hold logic");
  pll_wait_a: assert property (ce && $changed(clk_src) && clk_src != SFC_CLK_INT
    && clk_src != SFC_CLK_STOP |-> $past(lock_p[1]))
    else $error("clock switched before lock");
  byte_order_a: assert property (q_wr && !lo && ce && !q_clear
    |=> q_wdata == $past(word[7:0]))
    else $error("low byte did not follow high byte");
  trailer_last_a: assert property (q_wr && item == SFC_LAST_ITEM && lo
    && ce && !q_clear |=> pk_st == SFC_PK_IDLE)
    else $error("trailer word not last");
  pass_c: cover property (passthrough && fwd);
  burst_c: cover property (q_rd ##[1:400] q_rd);
  sample_c: cover property (q_wr && item == SFC_LAST_ITEM && lo);
endmodule : sfc_top
`default_nettype wire

/* File: common/sfc_pkg.sv */
// Shared constants and types for the sensor queue, control and power block
package sfc_pkg;
  localparam logic [6:0] SFC_DEV_ADDR = 7'h68;
  localparam logic [7:0] SFC_REG_CNT_H = 8'h3a;
  localparam logic [7:0] SFC_REG_CNT_L = 8'h3b;
  localparam logic [7:0] SFC_REG_QDATA = 8'h3c;
  localparam logic [7:0] SFC_REG_UCTRL = 8'h3d;
  localparam logic [7:0] SFC_REG_PWR = 8'h3e;
  localparam logic [7:0] SFC_UC_RST = 8'h00;
  localparam logic [7:0] SFC_PM_RST = 8'h00;
  localparam logic [7:0] SFC_UC_MASK = 8'hef;
  localparam int SFC_UC_COPROC_EN = 7;
  localparam int SFC_UC_QUEUE_EN = 6;
  localparam int SFC_UC_AUX_EN = 5;
  localparam int SFC_UC_AUX_RST = 3;
  localparam int SFC_UC_COPROC_RST = 2;
  localparam int SFC_UC_QUEUE_RST = 1;
  localparam int SFC_UC_GYRO_RST = 0;
  localparam int SFC_PM_HRESET = 7;
  localparam int SFC_PM_SLEEP = 6;
  localparam int SFC_PM_STBY_X = 5;
  localparam int SFC_PM_STBY_Y = 4;
  localparam int SFC_PM_STBY_Z = 3;
  localparam logic [2:0] SFC_CLK_INT = 3'h0;
  localparam logic [2:0] SFC_CLK_PLL_LO = 3'h1;
  localparam logic [2:0] SFC_CLK_PLL_HI = 3'h5;
  localparam logic [2:0] SFC_CLK_STOP = 3'h7;
  localparam int SFC_PTR_W = 9;
  localparam int SFC_CNT_W = 10;
  localparam logic [9:0] SFC_DEPTH = 10'h200;
  localparam logic [15:0] SFC_TRAILER = 16'h0000;
  localparam logic [2:0] SFC_LAST_ITEM = 3'h7;
  localparam logic [3:0] SFC_BYTE_BITS = 4'h8;

  typedef struct packed {
    logic [15:0] temp;
    logic [15:0] rate_x_sample;
    logic [15:0] rate_y_sample;
    logic [15:0] rate_z_sample;
    logic [15:0] accel_x_sample;
    logic [15:0] accel_y_sample;
    logic [15:0] accel_z_sample;
  } sfc_sample_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] data;
  } sfc_reg_req_t;

  typedef enum logic [2:0] {
    SFC_I_IDLE = 3'b000,
    SFC_I_RX = 3'b001,
    SFC_I_ACK = 3'b010,
    SFC_I_TX = 3'b011,
    SFC_I_MACK = 3'b100
  } sfc_i2c_st_t;

  typedef enum logic [0:0] {
    SFC_PK_IDLE = 1'b0,
    SFC_PK_RUN = 1'b1
  } sfc_pk_st_t;

  // Register pointer step; the queue data port does not advance
  function automatic logic [7:0] sfc_reg_inc(input logic [7:0] a);
    sfc_reg_inc = (a == SFC_REG_QDATA) ? a : 8'(a + 8'h01);
  endfunction : sfc_reg_inc
endpackage : sfc_pkg

/* File: hdl/sfc_queue.sv */
// Circular 512-byte sample queue with read prefetch
`timescale 1ns/1ps
`default_nettype none
module sfc_queue (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic clear,
  // Write side
  input wire logic wr,
  input wire logic [7:0] wr_data,
  // Read side
  input wire logic rd,
  output logic [7:0] rd_data,
  output logic [sfc_pkg::SFC_CNT_W-1:0] count
);
  import sfc_pkg::*;
  logic [7:0] mem [0:511];
  logic [SFC_PTR_W-1:0] wp, rp, next_wp, next_rp, nxt_rp;
  logic [SFC_CNT_W-1:0] next_count;
  logic [7:0] next_pf;
  logic full, do_rd;

  always_comb begin
    full = (count == SFC_DEPTH);
    do_rd = rd && (count != '0);
    nxt_rp = SFC_PTR_W'(rp + 1'b1);
    next_wp = wp;
    next_rp = rp;
    next_count = count;
    next_pf = rd_data;
    if (clear) begin
      next_wp = '0;
      next_rp = '0;
      next_count = '0;
      next_pf = 8'h00;
    end else begin
      if (wr) next_wp = SFC_PTR_W'(wp + 1'b1);
      if (do_rd || (wr && full)) next_rp = nxt_rp;
      if (wr && !do_rd && !full) next_count = SFC_CNT_W'(count + 1'b1);
      if (do_rd && !wr) next_count = SFC_CNT_W'(count - 1'b1);
      // Overwrite moves the oldest slot without refreshing the prefetch
      if (do_rd) next_pf = (wr && wp == nxt_rp) ? wr_data : mem[nxt_rp];
      else if (wr && count == '0) next_pf = wr_data;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      wp <= '0;
      rp <= '0;
      count <= '0;
      rd_data <= 8'h00;
    end else if (ce) begin
      wp <= next_wp;
      rp <= next_rp;
      count <= next_count;
      rd_data <= next_pf;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (ce && wr && !clear) mem[wp] <= wr_data;
  end

  circular_keep_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    ce && !clear && full && wr && !rd |=> count == SFC_DEPTH && rp == $past(nxt_rp))
    else $error("full queue did not overwrite oldest byte");
  count_sat_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    count <= SFC_DEPTH) else $error("queue count above depth");
  overflow_c: cover property (@(posedge ref_clk) disable iff (!rst_b) full && wr && ce);
endmodule : sfc_queue
`default_nettype wire

/* File: hdl/sfc_i2c_slave.sv */
// Primary serial bus register slave with sampled bus lines
`timescale 1ns/1ps
`default_nettype none
module sfc_i2c_slave (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic ce,
  // Bus lines
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_oe,
  output logic scl_s,
  output logic sda_s,
  // Register side
  output sfc_pkg::sfc_reg_req_t req,
  output logic [7:0] reg_addr,
  input wire logic [7:0] rd_data
);
  import sfc_pkg::*;
  logic [2:0] scl_p, sda_p;
  sfc_i2c_st_t st, next_st;
  sfc_reg_req_t next_req;
  logic [3:0] cnt, next_cnt;
  logic [7:0] sh, next_sh, next_addr;
  logic [1:0] idx, next_idx;
  logic rw, next_rw, nack, next_nack, next_oe;
  logic rise, fall, start, stop;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      scl_p <= 3'h7;
      sda_p <= 3'h7;
    end else if (ce) begin
      scl_p <= {scl_p[1:0], scl_in};
      sda_p <= {sda_p[1:0], sda_in};
    end
  end

  assign scl_s = scl_p[1];
  assign sda_s = sda_p[1];

  always_comb begin
    rise = scl_p[1] && !scl_p[2];
    fall = !scl_p[1] && scl_p[2];
    start = scl_p[1] && scl_p[2] && sda_p[2] && !sda_p[1];
    stop = scl_p[1] && scl_p[2] && !sda_p[2] && sda_p[1];
    next_st = st;
    next_req = '0;
    next_cnt = cnt;
    next_sh = sh;
    next_addr = reg_addr;
    next_idx = idx;
    next_rw = rw;
    next_nack = nack;
    next_oe = sda_oe;
    if (stop) begin
      next_st = SFC_I_IDLE;
      next_oe = 1'b0;
    end else if (start) begin
      next_st = SFC_I_RX;
      next_cnt = 4'h0;
      next_idx = 2'h0;
      next_oe = 1'b0;
    end else begin
      case (st)
        SFC_I_RX: begin
          if (rise) begin
            next_sh = {sh[6:0], sda_p[1]};
            next_cnt = 4'(cnt + 1'b1);
          end else if (fall && cnt == SFC_BYTE_BITS) begin
            next_cnt = 4'h0;
            next_st = SFC_I_ACK;
            next_oe = 1'b1;
            case (idx)
              2'h0: begin
                next_rw = sh[0];
                next_idx = 2'h1;
                if (sh[7:1] != SFC_DEV_ADDR) begin
                  next_st = SFC_I_IDLE;
                  next_oe = 1'b0;
                end
              end
              2'h1: begin
                next_addr = sh;
                next_idx = 2'h2;
              end
              default: begin
                next_req.wr = 1'b1;
                next_req.addr = reg_addr;
                next_req.data = sh;
                next_addr = sfc_reg_inc(reg_addr);
              end
            endcase
          end
        end
        SFC_I_ACK, SFC_I_MACK: begin
          if (rise) next_nack = sda_p[1];
          if (fall) begin
            next_oe = 1'b0;
            next_st = SFC_I_RX;
            if (st == SFC_I_MACK && nack) next_st = SFC_I_IDLE;
            else if (rw) begin
              next_req.rd = 1'b1;
              next_req.addr = reg_addr;
              next_addr = sfc_reg_inc(reg_addr);
              next_sh = rd_data;
              next_oe = !rd_data[7];
              next_cnt = 4'h0;
              next_st = SFC_I_TX;
            end
          end
        end
        SFC_I_TX: begin
          if (fall) begin
            if (cnt == 4'h7) begin
              next_oe = 1'b0;
              next_st = SFC_I_MACK;
            end else begin
              next_sh = {sh[6:0], 1'b0};
              next_oe = !sh[6];
              next_cnt = 4'(cnt + 1'b1);
            end
          end
        end
        default: next_st = SFC_I_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      st <= SFC_I_IDLE;
      req <= '0;
      cnt <= 4'h0;
      sh <= 8'h00;
      reg_addr <= 8'h00;
      idx <= 2'h0;
      rw <= 1'b0;
      nack <= 1'b0;
      sda_oe <= 1'b0;
    end else if (ce) begin
      st <= next_st;
      req <= next_req;
      cnt <= next_cnt;
      sh <= next_sh;
      reg_addr <= next_addr;
      idx <= next_idx;
      rw <= next_rw;
      nack <= next_nack;
      sda_oe <= next_oe;
    end
  end
endmodule : sfc_i2c_slave
`default_nettype wire

/* File: test/sfc_host.sv */
// Host processor model driving the primary serial bus
`timescale 1ns/1ps
`default_nettype none
module sfc_host (
  // Bus lines
  output logic scl,
  output logic sda_low,
  input wire logic sda_line,
  // Status
  output logic nack_seen
);
  import sfc_pkg::*;
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
    nack_seen = 1'b0;
  end
  task automatic bit_io(input logic b, output logic r);
    #31.25 sda_low = !b;
    #31.25 scl = 1'b1;
    #31.25 r = sda_line;
    #31.25 scl = 1'b0;
  endtask : bit_io
  task automatic start();
    #31.25 sda_low = 1'b0;
    #31.25 scl = 1'b1;
    #31.25 sda_low = 1'b1;
    #31.25 scl = 1'b0;
  endtask : start
  task automatic stop();
    #31.25 sda_low = 1'b1;
    #31.25 scl = 1'b1;
    #31.25 sda_low = 1'b0;
    #62.5;
  endtask : stop
  task automatic send(input logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
    end
    bit_io(1'b1, r);
    if (r) nack_seen = 1'b1;
  endtask : send
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    start();
    send({SFC_DEV_ADDR, 1'b0});
    send(a);
    send(d);
    stop();
  endtask : wr
  task automatic rd(input logic [7:0] a, input int n, ref logic [7:0] q[$]);
    logic r;
    logic [7:0] b;
    start();
    send({SFC_DEV_ADDR, 1'b0});
    send(a);
    start();
    send({SFC_DEV_ADDR, 1'b1});
    for (int k = 0; k < n; k++) begin
      for (int i = 7; i >= 0; i--) begin
        bit_io(1'b1, r);
        b[i] = r;
      end
      bit_io(k == n - 1, r);
      q.push_back(b);
    end
    stop();
  endtask : rd
endmodule : sfc_host
`default_nettype wire

/* File: test/sfc_top_tb.sv */
// Self-checking bench for the sensor queue, control and power block
`timescale 1ns/1ps
`default_nettype none
module sfc_top_tb;
  import sfc_pkg::*;
  logic ref_clk, rst_b, sample_strobe, pll_lock, scl, sda_low, nack_seen;
  logic sda_out, sda_oe, aux_scl_out, aux_scl_oe, aux_sda_out, aux_sda_oe, clock_stop;
  logic coproc_enable, coproc_reset, aux_master_enable, aux_reset, gyro_reset, passthrough;
  logic sleep, standby_gyro_x, standby_gyro_y, standby_gyro_z;
  logic [2:0] clk_src;
  logic [7:0] item_enable;
  logic [31:0] seed = 32'h49;
  logic [7:0] got[$];
  logic [7:0] exp_q[$];
  sfc_sample_t sample;
  int bad_count, compares;
  logic [3:0] seen = 4'h0;
  wire logic sda_line;
  assign sda_line = !(sda_low || sda_oe);
  sfc_top sfc_top_inst (
    .ref_clk, .rst_b, .ce(1'b1), .scl_in(scl), .sda_in(sda_line), .sda_out, .sda_oe,
    .aux_sda_in(1'b1), .aux_scl_out, .aux_scl_oe, .aux_sda_out, .aux_sda_oe,
    .sample_strobe, .sample, .item_enable, .pll_lock, .clk_src, .clock_stop,
    .coproc_enable, .coproc_reset, .aux_master_enable, .aux_reset, .gyro_reset,
    .passthrough, .sleep, .standby_gyro_x, .standby_gyro_y, .standby_gyro_z
  );
  sfc_host sfc_host_inst (.scl, .sda_low, .sda_line, .nack_seen);
  // Remembers secondary drive and reset pulses seen at any rising ref_clk edge
  always @(posedge ref_clk) seen <= seen | {aux_scl_oe, aux_sda_oe, aux_reset, coproc_reset};
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  task automatic check(input logic [15:0] g, input logic [15:0] e, input string m);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED at %0t: %s got %h want %h", $time, m, g, e);
    end
  endtask : check
  task automatic finish_test();
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : finish_test
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfc_host_inst.wr(a, d);
  endtask : wr
  task automatic rdq(input logic [7:0] a, input int n);
    got.delete();
    sfc_host_inst.rd(a, n, got);
  endtask : rdq
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    rdq(a, 1);
    check(16'(got[0]), 16'(e), "register");
  endtask : rchk
  task automatic cnt_chk(input logic [15:0] e);
    rdq(SFC_REG_CNT_H, 2);
    check({6'h00, got[0][1:0], got[1]}, e, "byte count");
  endtask : cnt_chk
  task automatic qread(input int n);
    rdq(SFC_REG_QDATA, n);
    foreach (got[k]) check(16'(got[k]), 16'(exp_q.pop_front()), "queue byte");
  endtask : qread
  task automatic push(input int n, input logic [7:0] en);
    logic [127:0] r;
    repeat (n) begin
      r = {rnd(), rnd(), rnd(), rnd()};
      @(posedge ref_clk);
      #1;
      sample = r[111:0];
      item_enable = en;
      sample_strobe = 1'b1;
      @(posedge ref_clk);
      #1;
      sample_strobe = 1'b0;
      for (int i = 0; i < 7; i++) begin
        if (en[i]) begin
          exp_q.push_back(sample[111-16*i -: 8]);
          exp_q.push_back(sample[103-16*i -: 8]);
        end
      end
      if (en[7]) begin
        exp_q.push_back(SFC_TRAILER[15:8]);
        exp_q.push_back(SFC_TRAILER[7:0]);
      end
      while (exp_q.size() > 512) exp_q.pop_front();
      repeat (20) @(posedge ref_clk);
    end
  endtask : push
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = !ref_clk;
  end
  initial begin
    repeat (95000) @(posedge ref_clk);
    bad_count++;
    finish_test();
  end
  initial begin
    logic [7:0] v;
    logic [2:0] src;
    rst_b = 1'b0;
    sample_strobe = 1'b0;
    pll_lock = 1'b0;
    item_enable = 8'h00;
    sample = '0;
    repeat (6) @(posedge ref_clk);
    #1;
    rst_b = 1'b1;
    repeat (4) @(posedge ref_clk);
    rchk(SFC_REG_UCTRL, SFC_UC_RST);
    rchk(SFC_REG_PWR, SFC_PM_RST);
    rchk(8'h00, 8'h00);
    check(16'(clk_src), 16'(SFC_CLK_INT), "clock source");
    $display("test reset values done");
    wr(SFC_REG_UCTRL, 8'h52);
    rchk(SFC_REG_UCTRL, 8'h40);
    push(2, 8'hff);
    cnt_chk(16'h0020);
    qread(30);
    push(1, 8'hff);
    qread(16);
    cnt_chk(16'h0002);
    $display("test queue order done");
    push(40, 8'hff);
    cnt_chk(16'h0200);
    rdq(SFC_REG_QDATA, 20);
    void'(exp_q.pop_front());
    for (int k = 1; k < 20; k++) begin
      check(16'(got[k]), 16'(exp_q.pop_front()), "overflow byte");
    end
    wr(SFC_REG_UCTRL, 8'h42);
    exp_q.delete();
    cnt_chk(16'h0000);
    $display("test overflow done");
    wr(SFC_REG_PWR, 8'h01);
    check(16'(clk_src), 16'(SFC_CLK_INT), "clock before lock");
    pll_lock = 1'b1;
    repeat (10) @(posedge ref_clk);
    check(16'(clk_src), 16'h0001, "clock after lock");
    src = 3'h1;
    for (int c = 0; c < 8; c++) begin
      v = 8'(rnd());
      v = {1'b0, v[6:3], c[2:0]};
      wr(SFC_REG_PWR, v);
      if (c != 6) src = v[2:0];
      check(16'(clk_src), 16'(src), "clock source");
      check(16'(clock_stop), 16'(c == 7), "clock stop");
      check(16'({sleep, standby_gyro_x, standby_gyro_y, standby_gyro_z}), 16'(v[6:3]), "power");
      rchk(SFC_REG_PWR, v);
    end
    wr(SFC_REG_PWR, 8'h80);
    rchk(SFC_REG_UCTRL, 8'h00);
    rchk(SFC_REG_PWR, 8'h00);
    check(16'(clk_src), 16'h0000, "clock after hard reset");
    $display("test power register done");
    wr(SFC_REG_UCTRL, 8'h08);
    check(16'(passthrough), 16'h0001, "pass-through on");
    check(16'({aux_scl_oe, aux_sda_oe}), 16'h0000, "aux lines idle");
    wr(SFC_REG_UCTRL, 8'hac);
    check(16'({coproc_enable, aux_master_enable, passthrough}), 16'h0006, "enables");
    rchk(SFC_REG_UCTRL, 8'ha0);
    check(16'(seen), 16'h000f, "aux drive and reset pulses");
    check(16'({sda_out, aux_scl_out, aux_sda_out}), 16'h0000, "drive levels");
    check(16'(nack_seen), 16'h0000, "bus acknowledge");
    $display("test control register done");
    finish_test();
  end
endmodule : sfc_top_tb
`default_nettype wire
